/* File: bold_load_model.sv */
module bold_load_model (
	input wire logic core_clk,
	input wire logic [3:0] test_high_on,
	input wire logic [1:0] open_load,
	output logic [1:0] half_vbat_compare_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial half_vbat_compare_in = 2'h0;
	always @(posedge core_clk) begin
		half_vbat_compare_in <= {test_high_on[2], test_high_on[0]} & ~open_load;
	end
endmodule : bold_load_model

/* File: bold_open_load.sv */
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Monitoring and low current: qualification counter increments.
// - Monitoring and current above threshold: counter cleared and held.
// - Not monitoring but masked: counter cleared.
// - Neither monitoring nor masked: counter frozen.
// - Running flag set after 100 ms of low current.
// - Running flag clears only on current above threshold while monitoring; a mask clear keeps it.
// - Disabled or in fault high impedance: no monitoring, flag keeps its value.
// - Running flag is status only, never touches drive.
// - Running flag copied into status every cycle.
// - Monitoring means exactly one high side of a channel on.
// - Mask in initial diagnosis, disable, fault high impedance, sleep.
// - Initial diagnosis only checks the comparator, runs no test.
// - Host selects test duration; each test uses it.
// - Switching judged against half battery voltage comparator.
// - Start only from zero-duty brake or serial brake.
// - Faults and diagnosis abort test; outputs go high impedance.
// - Aborted test leaves result bits 18 and 17 at zero.
// - Under-voltage off state never counts as a test start.
// - Test drives one transistor, watches the opposite output.
// - Sleep input low stops logic and monitoring.
//////////////////////////////////////////////////////////////////////////////
module bold_open_load (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sleep_request_n,
	input wire logic [1:0] drive_enable_lo,
	input wire logic [1:0] drive_enable_hi,
	input wire logic [3:0] high_side_on,
	input wire logic [1:0] low_current_compare_in,
	input wire logic [1:0] half_vbat_compare_in,
	input wire logic initial_fault_indicator_out_active,
	input wire logic undervoltage_fault,
	input wire logic overcurrent_fault,
	input wire logic overtemp_fault,
	input wire logic [1:0] fault_hiz_active,
	input wire logic [1:0] stopped_by_zero_duty,
	input wire logic [1:0] stopped_by_serial,
	input wire logic [1:0] stop_exec_wr,
	input wire logic [1:0] stop_test_sel,
	input wire logic [1:0] stop_result_clr,
	output logic [1:0] running_open_load_flag,
	output logic [1:0] status_running_open,
	output logic [1:0] stop_open_result,
	output logic [1:0] stop_test_busy,
	output logic [3:0] test_high_on,
	output logic [3:0] test_low_on,
	output logic [1:0] test_abort_hiz,
	output logic [1:0] fault_indicator_out_o,
	output logic [1:0] fault_indicator_out_oe
);
	//////////////////////////////////////////////////////////////////////////
	localparam int TEST_LEN_W = bold_pkg::TEST_W;
	logic [1:0] lc_sync;
	logic [1:0] hv_sync;
	logic [1:0] en_lo_sync;
	logic [1:0] en_hi_sync;
	logic sleep_n_sync;
	logic awake;
	logic any_fault;
	logic [TEST_LEN_W-1:0] dur_cyc;
	genvar gi;

	// Sleep pin is asynchronous; its synchroniser resets low, so the block
	// stays masked for a few cycles after reset until the pin level arrives
	bold_sync3 u_sleep (
		.core_clk(core_clk),
		.rst(rst),
		.pin_in(sleep_request_n),
		.level_out(sleep_n_sync)
	);

	assign awake = sleep_n_sync;
	assign any_fault = undervoltage_fault || overcurrent_fault || overtemp_fault || initial_fault_indicator_out_active;

	always_comb begin
		case (stop_test_sel)
			2'h0: dur_cyc = TEST_LEN_W'(bold_pkg::STOP_TEST_CYC_0);
			2'h1: dur_cyc = TEST_LEN_W'(bold_pkg::STOP_TEST_CYC_1);
			2'h2: dur_cyc = TEST_LEN_W'(bold_pkg::STOP_TEST_CYC_2);
			default: dur_cyc = TEST_LEN_W'(bold_pkg::STOP_TEST_CYC_3);
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ch
			logic enabled;
			logic mask_any;
			logic start_ok;
			logic abort;
			bold_pkg::bold_test_state_t st_r;
			logic [TEST_LEN_W-1:0] tcnt_r;
			logic [TEST_LEN_W-1:0] tlen_r;
			logic seen_r;
			logic res_r;

			// Comparators and enable pins cross from outside the oscillator domain
			bold_sync3 u_lc (
				.core_clk(core_clk),
				.rst(rst),
				.pin_in(low_current_compare_in[gi]),
				.level_out(lc_sync[gi])
			);
			bold_sync3 u_hv (
				.core_clk(core_clk),
				.rst(rst),
				.pin_in(half_vbat_compare_in[gi]),
				.level_out(hv_sync[gi])
			);
			bold_sync3 u_en_lo (
				.core_clk(core_clk),
				.rst(rst),
				.pin_in(drive_enable_lo[gi]),
				.level_out(en_lo_sync[gi])
			);
			bold_sync3 u_en_hi (
				.core_clk(core_clk),
				.rst(rst),
				.pin_in(drive_enable_hi[gi]),
				.level_out(en_hi_sync[gi])
			);

			assign enabled = en_hi_sync[gi] && !en_lo_sync[gi];
			assign mask_any = initial_fault_indicator_out_active || !enabled || fault_hiz_active[gi] || !awake;

			bold_run_channel u_run (
				.core_clk(core_clk),
				.rst(rst),
				.high_a_on(high_side_on[2*gi]),
				.high_b_on(high_side_on[2*gi+1]),
				.compare_low(!lc_sync[gi]),
				.mask_any(mask_any),
				.logic_active(awake),
				.open_flag_r(running_open_load_flag[gi])
			);

			assign status_running_open[gi] = running_open_load_flag[gi];

			assign start_ok = awake && enabled && !any_fault && !fault_hiz_active[gi]
				&& (stopped_by_zero_duty[gi] || stopped_by_serial[gi]);
			assign abort = any_fault || !awake;

			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					st_r <= bold_pkg::BOLD_IDLE;
					tcnt_r <= '0;
					tlen_r <= '0;
					seen_r <= 1'b0;
				end else begin
					case (st_r)
						bold_pkg::BOLD_IDLE: begin
							if (stop_exec_wr[gi] && start_ok) begin
								st_r <= bold_pkg::BOLD_DRIVE;
								tcnt_r <= '0;
								tlen_r <= dur_cyc;
								seen_r <= 1'b0;
							end
						end
						bold_pkg::BOLD_DRIVE: begin
							if (abort) begin
								st_r <= bold_pkg::BOLD_IDLE;
							end else if (tcnt_r == tlen_r - 1'b1) begin
								st_r <= bold_pkg::BOLD_DONE;
							end else begin
								tcnt_r <= tcnt_r + 1'b1;
							end
							if (hv_sync[gi]) begin
								seen_r <= 1'b1;
							end
						end
						default: begin
							st_r <= bold_pkg::BOLD_IDLE;
						end
					endcase
				end
			end

			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					res_r <= bold_pkg::STOP_RES_RST;
				// unswitched output flags open; abort never reaches here
				end else if (st_r == bold_pkg::BOLD_DONE && !seen_r) begin
					res_r <= 1'b1;
				end else if (stop_result_clr[gi] || (st_r == bold_pkg::BOLD_IDLE && stop_exec_wr[gi] && start_ok)) begin
					res_r <= 1'b0;
				end
			end
			assign stop_open_result[gi] = res_r;
			assign stop_test_busy[gi] = (st_r == bold_pkg::BOLD_DRIVE);

			// single high side, opposite output watched
			assign test_high_on[2*gi] = (st_r == bold_pkg::BOLD_DRIVE);
			assign test_high_on[2*gi+1] = 1'b0;
			assign test_low_on[2*gi] = 1'b0;
			assign test_low_on[2*gi+1] = 1'b0;
			assign test_abort_hiz[gi] = (st_r == bold_pkg::BOLD_DRIVE) && abort;

			// open-drain low on flag or stop result; flag feeds no drive path
			assign fault_indicator_out_o[gi] = 1'b0;
			assign fault_indicator_out_oe[gi] = running_open_load_flag[gi] || res_r;
		end
	endgenerate
endmodule : bold_open_load

/* File: bold_open_load_assertions.sv */
module bold_open_load_assertions (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sleep_request_n,
	input wire logic [1:0] drive_enable_lo,
	input wire logic [1:0] drive_enable_hi,
	input wire logic undervoltage_fault,
	input wire logic overcurrent_fault,
	input wire logic initial_fault_indicator_out_active,
	input wire logic [1:0] stop_exec_wr,
	input wire logic [1:0] running_open_load_flag,
	input wire logic [1:0] status_running_open,
	input wire logic [1:0] stop_open_result,
	input wire logic [1:0] stop_test_busy,
	input wire logic [3:0] test_high_on,
	input wire logic [3:0] test_low_on,
	input wire logic [1:0] test_abort_hiz,
	input wire logic [1:0] fault_indicator_out_o,
	input wire logic [1:0] fault_indicator_out_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_status_copy: assert property (status_running_open == running_open_load_flag)
		else $error("status copy differs from flag");
	a_pull_low_cause: assert property (fault_indicator_out_oe == (running_open_load_flag | stop_open_result))
		else $error("fault pin enable has wrong cause");
	a_pin_drives_low: assert property (fault_indicator_out_o == 2'h0)
		else $error("fault pin drives high");
	a_one_switch: assert property (stop_test_busy[0] |-> $onehot({test_high_on[1:0], test_low_on[1:0]}))
		else $error("test switches more than one transistor");
	a_idle_no_switch: assert property (!stop_test_busy[0] |-> {test_high_on[1:0], test_low_on[1:0]} == 4'h0)
		else $error("transistor on while idle");
	a_fault_abort: assert property (stop_test_busy[0] && overcurrent_fault |-> ##[1:3] !stop_test_busy[0])
		else $error("fault did not abort test");
	a_abort_no_result: assert property (stop_test_busy[0] && overcurrent_fault |=> !stop_open_result[0] [*4])
		else $error("aborted test set result");
	a_refuse_exec: assert property (stop_exec_wr[0] && !stop_test_busy[0]
		&& (!sleep_request_n || drive_enable_lo[0] || !drive_enable_hi[0]) |=> !stop_test_busy[0])
		else $error("test started while asleep or disabled");
	a_fault_indicator_out_no_start: assert property (stop_exec_wr[1] && !stop_test_busy[1] && initial_fault_indicator_out_active |=> !stop_test_busy[1])
		else $error("test started during initial diagnosis");
	a_abort_hiz: assert property (stop_test_busy[0] && overcurrent_fault |-> test_abort_hiz[0])
		else $error("abort did not request high impedance");
	a_uv_no_start: assert property (stop_exec_wr[1] && !stop_test_busy[1] && undervoltage_fault |=> !stop_test_busy[1])
		else $error("test started in under-voltage");
	c_test_run: cover property ($rose(stop_test_busy[0]));
	c_open_found: cover property ($rose(stop_open_result[1]));
	c_abort: cover property (stop_test_busy[0] && overcurrent_fault);
endmodule : bold_open_load_assertions
bind bold_open_load bold_open_load_assertions i_bold_open_load_assertions (.*);

/* File: bold_open_load_tb_top.sv */
module bold_open_load_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rst = 1, sleep_request_n = 1, initial_fault_indicator_out_active = 0, undervoltage_fault = 0;
	logic overcurrent_fault = 0, overtemp_fault = 0;
	logic [1:0] drive_enable_lo = 0, drive_enable_hi = 0, low_current_compare_in = 0, half_vbat_compare_in;
	logic [1:0] fault_hiz_active = 0, stopped_by_zero_duty = 0, stopped_by_serial = 0, stop_exec_wr = 0;
	logic [1:0] stop_test_sel = 0, stop_result_clr = 0, open_load = 2'h2;
	logic [3:0] high_side_on = 0;
	logic [1:0] running_open_load_flag, status_running_open, stop_open_result, stop_test_busy, test_abort_hiz;
	logic [1:0] fault_indicator_out_o, fault_indicator_out_oe;
	logic [3:0] test_high_on, test_low_on;
	int errors = 0, compares = 0, exp_n[$];
	logic [1:0] exp_r[$];
	bold_open_load i_bold_open_load (.*);
	// Channel 1 load is disconnected
	bold_load_model i_bold_load_model (.*);
	initial forever #12.5 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %0h seen %0h", name, exp, got);
		end
	endtask : check
	// Settle conditions first: some levels pass synchronisers
	task automatic exec(input int ch, input logic [1:0] sel, input int n, input logic [1:0] r, input bit go);
		repeat (5) @(posedge core_clk);
		if (go) begin
			exp_n.push_back(n);
			exp_r.push_back(r);
		end
		stop_test_sel <= sel;
		stop_exec_wr[ch] <= 1'b1;
		@(posedge core_clk);
		stop_exec_wr <= 2'h0;
		if (!go) begin
			repeat (2) @(negedge core_clk);
			check("refused busy", 0, stop_test_busy);
			@(posedge core_clk);
		end
	endtask : exec
	task automatic drain;
		for (int k = 0; k < 30000 && exp_n.size() > 0; k++) @(posedge core_clk);
		if (exp_n.size() > 0) begin
			errors++;
			print_verdict;
		end
	endtask : drain
	////////////////////////////////////////////////////////////////////////////
	// Load conditions wander while the stopped tests run
	always @(posedge core_clk) begin
		if (!rst && $urandom % 64 == 0) begin
			high_side_on <= 4'($urandom);
			low_current_compare_in <= 2'($urandom);
		end
	end
	initial begin : watch
		int k;
		int n;
		forever begin
			@(negedge core_clk);
			if (stop_test_busy !== 2'h0) begin
				for (k = 0; stop_test_busy !== 2'h0 && k < 30000; k++) @(negedge core_clk);
				if (k >= 30000) begin
					errors++;
					print_verdict;
				end
				@(negedge core_clk);
				n = exp_n.pop_front();
				if (n >= 0) check("busy cycles", n, k);
				check("stop result", exp_r.pop_front(), stop_open_result);
			end
		end
	end
	initial begin
		logic [1:0] sel;
		int n;
		void'($urandom(32'he964));
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		check("reset outputs", 0, {stop_open_result, stop_test_busy, fault_indicator_out_oe});
		@(posedge core_clk);
		drive_enable_hi <= 2'h3;
		stopped_by_serial <= 2'h3;
		sel = 2'($urandom % 2);
		n = sel ? bold_pkg::STOP_TEST_CYC_1 : bold_pkg::STOP_TEST_CYC_0;
		exec(0, sel, n, 2'h0, 1);
		drain;
		exec(1, sel, n, 2'h2, 1);
		drain;
		check("fault pin", 2, fault_indicator_out_oe);
		drive_enable_lo <= 2'h1;
		exec(0, 0, 0, 0, 0);
		drive_enable_lo <= 2'h0;
		sleep_request_n <= 1'b0;
		exec(0, 0, 0, 0, 0);
		sleep_request_n <= 1'b1;
		undervoltage_fault <= 1'b1;
		exec(1, 0, 0, 0, 0);
		undervoltage_fault <= 1'b0;
		initial_fault_indicator_out_active <= 1'b1;
		exec(1, 0, 0, 0, 0);
		initial_fault_indicator_out_active <= 1'b0;
		stopped_by_serial <= 2'h0;
		stopped_by_zero_duty <= 2'h1;
		exec(1, 0, 0, 0, 0);
		exec(0, 0, -1, 2'h2, 1);
		repeat (100) @(posedge core_clk);
		overcurrent_fault <= 1'b1;
		drain;
		overcurrent_fault <= 1'b0;
		check("running flag", 0, running_open_load_flag);
		stop_result_clr <= 2'h2;
		@(posedge core_clk);
		stop_result_clr <= 2'h0;
		@(negedge core_clk);
		check("result clear", 0, {stop_open_result, fault_indicator_out_oe});
		print_verdict;
	end
endmodule : bold_open_load_tb_top

/* File: bold_pkg.sv */
package bold_pkg;
	// Internal oscillator rate and running detection time
	localparam int unsigned OSC_HZ = 40000000;
	localparam int unsigned RUN_DETECT_MS = 100;
	localparam int unsigned RUN_DETECT_CYC = OSC_HZ / 1000 * RUN_DETECT_MS;
	localparam int CNT_W = 23;
	// Stopped-test duration choices, in microseconds
	localparam int unsigned STOP_TEST_US_0 = 100;
	localparam int unsigned STOP_TEST_US_1 = 500;
	localparam int unsigned STOP_TEST_US_2 = 1000;
	localparam int unsigned STOP_TEST_US_3 = 5000;
	localparam int unsigned STOP_TEST_CYC_0 = OSC_HZ / 1000000 * STOP_TEST_US_0;
	localparam int unsigned STOP_TEST_CYC_1 = OSC_HZ / 1000000 * STOP_TEST_US_1;
	localparam int unsigned STOP_TEST_CYC_2 = OSC_HZ / 1000000 * STOP_TEST_US_2;
	localparam int unsigned STOP_TEST_CYC_3 = OSC_HZ / 1000000 * STOP_TEST_US_3;
	localparam int TEST_W = 18;
	// Execute bit positions in setup_word_seven, result bits in fault_report_word
	localparam int EXEC_BIT_A = 30;
	localparam int EXEC_BIT_B = 27;
	localparam int RESULT_BIT_A = 18;
	localparam int RESULT_BIT_B = 17;
	localparam logic RUN_FLAG_RST = 1'b0;
	localparam logic STOP_RES_RST = 1'b0;
	typedef enum logic [1:0] {BOLD_IDLE, BOLD_DRIVE, BOLD_DONE} bold_test_state_t;
endpackage : bold_pkg

/* File: bold_run_channel.sv */
module bold_run_channel (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic high_a_on,
	input wire logic high_b_on,
	input wire logic compare_low,
	input wire logic mask_any,
	input wire logic logic_active,
	output logic open_flag_r
);
	logic [bold_pkg::CNT_W-1:0] cnt_r;
	logic monitor;

	assign monitor = logic_active && (high_a_on ^ high_b_on);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
		end else if (monitor && !mask_any) begin
			if (compare_low) begin
				if (cnt_r != bold_pkg::CNT_W'(bold_pkg::RUN_DETECT_CYC)) begin
					cnt_r <= cnt_r + 1'b1;
				end
			end else begin
				cnt_r <= '0;
			end
		end else if (mask_any) begin
			cnt_r <= '0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			open_flag_r <= bold_pkg::RUN_FLAG_RST;
		end else if (monitor && !mask_any) begin
			if (compare_low && cnt_r == bold_pkg::CNT_W'(bold_pkg::RUN_DETECT_CYC - 1)) begin
				open_flag_r <= 1'b1;
			end else if (!compare_low) begin
				open_flag_r <= 1'b0;
			end
		end
	end
endmodule : bold_run_channel

/* File: bold_sync3.sv */
module bold_sync3 (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic pin_in,
	output logic level_out
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			level_out <= 1'b0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// Accept a change once two later stages agree
			if (s2_r == s3_r) begin
				level_out <= s3_r;
			end
		end
	end
endmodule : bold_sync3
